// ==== design/rtc_alarm_pkg.sv ====
package rtc_alarm_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 25_000_000;
   // width of one repeat-mode interrupt pulse on the open-drain pin
   localparam int unsigned PULSE_TIME_US = 10;
   localparam int unsigned PULSE_CYCLES  = (PULSE_TIME_US * CLK_HZ + 999_999) / 1_000_000;
   localparam logic [7:0]  PULSE_LAST    = 8'(PULSE_CYCLES - 1);

   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_ALARM_SECONDS     = 4'h0;
   localparam logic [3:0] IDX_ALARM_MINUTES     = 4'h1;
   localparam logic [3:0] IDX_ALARM_HOURS       = 4'h2;
   localparam logic [3:0] IDX_ALARM_DATE        = 4'h3;
   localparam logic [3:0] IDX_ALARM_MONTH       = 4'h4;
   localparam logic [3:0] IDX_ALARM_WEEKDAY     = 4'h5;
   localparam logic [3:0] IDX_INTERRUPT_CONTROL = 4'h6;
   localparam logic [3:0] IDX_STATUS            = 4'h7;
   localparam logic [3:0] IDX_BACKUP_CONTROL    = 4'h8;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned FIELD_ENABLE_BIT   = 7;
   localparam int unsigned REPEAT_MODE_BIT    = 7;
   localparam int unsigned ALARM0_ENABLE_BIT  = 5;
   localparam int unsigned STATUS_ALARM0_BIT  = 0;
   localparam int unsigned STATUS_BACKUP_BIT  = 1;
   localparam int unsigned STATUS_BUS_BIT     = 2;
   localparam int unsigned SWITCHOVER_BIT     = 0;
   localparam int unsigned BUS_INHIBIT_BIT    = 1;
   localparam logic [7:0]  ALARM_RESET        = 8'h00;
   localparam logic [7:0]  INT_CTRL_RESET     = 8'h00;
   localparam logic [1:0]  BACKUP_CTRL_RESET  = 2'h0;
   localparam logic [7:0]  SECONDS_ROLLOVER   = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] seconds;
      logic [7:0] minutes;
      logic [7:0] hours;
      logic [7:0] date;
      logic [7:0] month;
      logic [7:0] weekday;
   } time_bcd_t;

   typedef struct packed {
      logic       write_en;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // encoded as {serial_bus_inhibit, switchover_select}
   typedef enum logic [1:0] {
      MODE_A = 2'b00,
      MODE_B = 2'b01,
      MODE_C = 2'b10,
      MODE_D = 2'b11
   } backup_mode_t;

   typedef enum logic [1:0] {
      IRQ_IDLE  = 2'b00,
      IRQ_HOLD  = 2'b01,
      IRQ_PULSE = 2'b10
   } irq_state_t;

endpackage

// ==== design/alarm_field_cmp.sv ====
`timescale 1ns/10ps
module alarm_field_cmp
   import rtc_alarm_pkg::*;
(
   // alarm byte and live counter
   input  wire logic [7:0] alarm_byte,
   input  wire logic [7:0] count_byte,
   // result
   output logic            field_ok,
   output logic            field_en
);

   // ----------------------------------------------------------------
   // compare
   // ----------------------------------------------------------------
   // a field with its enable clear is a don't-care, whatever its value
   always_comb
   begin
      field_en = alarm_byte[FIELD_ENABLE_BIT];
      field_ok = !field_en || (alarm_byte[6:0] == count_byte[6:0]);
   end

endmodule

// ==== design/backup_mode_ctrl.sv ====
`timescale 1ns/10ps
module backup_mode_ctrl
   import rtc_alarm_pkg::*;
(
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         srst,
   // supply comparators, asynchronous
   input  wire logic         vdd_below_trip,
   input  wire logic         vdd_below_bat,
   // mode selection
   input  wire backup_mode_t mode,
   // state
   output logic              in_backup,
   output logic              bus_enable
);

   logic [1:0] trip_sync_reg;
   logic [1:0] bat_sync_reg;
   logic       backup_next;

   // ----------------------------------------------------------------
   // comparator synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         trip_sync_reg <= 2'h0;
         bat_sync_reg  <= 2'h0;
      end
      else
      begin
         trip_sync_reg <= {trip_sync_reg[0], vdd_below_trip};
         bat_sync_reg  <= {bat_sync_reg[0], vdd_below_bat};
      end
   end

   // ----------------------------------------------------------------
   // switchover decision
   // ----------------------------------------------------------------
   // standard: below the lower of trip and battery; legacy: below battery
   always_comb
   begin
      case (mode)
         MODE_A:  backup_next = trip_sync_reg[1] && bat_sync_reg[1];
         MODE_B:  backup_next = bat_sync_reg[1];
         MODE_C:  backup_next = trip_sync_reg[1] && bat_sync_reg[1];
         MODE_D:  backup_next = bat_sync_reg[1];
         default: backup_next = trip_sync_reg[1] && bat_sync_reg[1];
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         in_backup  <= 1'b0;
         bus_enable <= 1'b1;
      end
      else
      begin
         in_backup  <= backup_next;
         // inhibit only bites while on battery
         bus_enable <= !(backup_next && mode[1]);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_legacy_switch: assert property (@(posedge clk_sys) disable iff (srst)
      (mode == MODE_B && bat_sync_reg[1]) |=> in_backup)
      else $error("legacy switchover missed battery crossing");

   a_standard_switch: assert property (@(posedge clk_sys) disable iff (srst)
      (mode == MODE_A && !trip_sync_reg[1]) |=> !in_backup)
      else $error("standard switchover entered backup above trip");

   a_bus_inhibit: assert property (@(posedge clk_sys) disable iff (srst)
      (mode[1] && backup_next) |=> (in_backup && !bus_enable))
      else $error("serial bus left enabled in inhibited backup");

   a_bus_kept: assert property (@(posedge clk_sys) disable iff (srst)
      (!mode[1]) |=> bus_enable)
      else $error("serial bus disabled without inhibit");

endmodule

// ==== design/rtc_alarm_and_backup_mode.sv ====
`timescale 1ns/10ps
// Functional notes
// - bit 7 enables field, rest BCD target
// - disabled field is left out of comparison
// - hours field takes BCD hours with enable
// - alarm events need control bit 5 set
// - single event fires at exact time, rollover
// - match sets flag and drives output low
// - repeat mode bit selects pulsed interrupts
// - seconds-only 30 pulses once a minute
// - pulses repeat regardless of flag clearing
// - mode B legacy switchover, bus kept
// - mode C standard switchover, bus off
// - mode D legacy switchover, bus off
// - interrupt output stays active in backup
// - mode bits encode B=01, C=10, D=11
// - power-up defaults to standard switchover
module rtc_alarm_and_backup_mode
   import rtc_alarm_pkg::*;
(
   // clock and reset
   input  wire logic      clk_sys,
   input  wire logic      srst,
   // register port from the serial front end
   input  wire reg_req_t  reg_req,
   output logic [7:0]     reg_rdata,
   output logic           reg_ready,
   // calendar counters, same clock
   input  wire time_bcd_t cur_time,
   input  wire logic      sec_tick,
   // supply comparators
   input  wire logic      vdd_below_trip,
   input  wire logic      vdd_below_bat,
   // open-drain interrupt pin
   output logic           irq_out,
   output logic           irq_oe,
   // supply state
   output logic           backup_active,
   output logic           bus_active
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   time_bcd_t    alarm_reg;
   logic [7:0]   int_ctrl_reg;
   logic [1:0]   backup_ctrl_reg;
   logic         flag_reg;
   logic         flag_next;
   irq_state_t   state_reg;
   irq_state_t   state_next;
   logic [7:0]   pulse_cnt_reg;
   logic [7:0]   pulse_cnt_next;
   logic [7:0]   rdata_next;
   logic [5:0]   field_ok;
   logic [5:0]   field_en;
   logic         all_ok;
   logic         eval_point;
   logic         match_evt;
   logic         repeat_mode;
   logic         alarm_on;
   logic         wr_ok;
   logic         flag_clear;
   logic         in_backup;
   logic         bus_enable;
   backup_mode_t mode;

   // ----------------------------------------------------------------
   // field comparators
   // ----------------------------------------------------------------
   alarm_field_cmp u_cmp_seconds
   (
      .alarm_byte (alarm_reg.seconds),
      .count_byte (cur_time.seconds),
      .field_ok   (field_ok[0]),
      .field_en   (field_en[0])
   );

   alarm_field_cmp u_cmp_minutes
   (
      .alarm_byte (alarm_reg.minutes),
      .count_byte (cur_time.minutes),
      .field_ok   (field_ok[1]),
      .field_en   (field_en[1])
   );

   // hours compared on the same 7-bit BCD value as every other field
   alarm_field_cmp u_cmp_hours
   (
      .alarm_byte (alarm_reg.hours),
      .count_byte (cur_time.hours),
      .field_ok   (field_ok[2]),
      .field_en   (field_en[2])
   );

   alarm_field_cmp u_cmp_date
   (
      .alarm_byte (alarm_reg.date),
      .count_byte (cur_time.date),
      .field_ok   (field_ok[3]),
      .field_en   (field_en[3])
   );

   alarm_field_cmp u_cmp_month
   (
      .alarm_byte (alarm_reg.month),
      .count_byte (cur_time.month),
      .field_ok   (field_ok[4]),
      .field_en   (field_en[4])
   );

   alarm_field_cmp u_cmp_weekday
   (
      .alarm_byte (alarm_reg.weekday),
      .count_byte (cur_time.weekday),
      .field_ok   (field_ok[5]),
      .field_en   (field_en[5])
   );

   // ----------------------------------------------------------------
   // backup switchover
   // ----------------------------------------------------------------
   assign mode = backup_mode_t'({backup_ctrl_reg[BUS_INHIBIT_BIT],
                                 backup_ctrl_reg[SWITCHOVER_BIT]});

   backup_mode_ctrl u_backup
   (
      .clk_sys        (clk_sys),
      .srst           (srst),
      .vdd_below_trip (vdd_below_trip),
      .vdd_below_bat  (vdd_below_bat),
      .mode           (mode),
      .in_backup      (in_backup),
      .bus_enable     (bus_enable)
   );

   // ----------------------------------------------------------------
   // match evaluation
   // ----------------------------------------------------------------
   // with seconds disabled the match is taken only as seconds roll to 00,
   // so a minute-level alarm fires once rather than sixty times
   always_comb
   begin
      all_ok      = &field_ok;
      repeat_mode = int_ctrl_reg[REPEAT_MODE_BIT];
      alarm_on    = int_ctrl_reg[ALARM0_ENABLE_BIT];
      eval_point  = sec_tick && (field_en[0] || cur_time.seconds == SECONDS_ROLLOVER);
      match_evt   = alarm_on && eval_point && all_ok;
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // writes are dropped while the serial bus is inhibited on battery
   always_comb
   begin
      wr_ok      = reg_req.write_en && bus_enable;
      flag_clear = wr_ok && reg_req.addr == IDX_STATUS && !reg_req.wdata[STATUS_ALARM0_BIT];
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         alarm_reg    <= {6{ALARM_RESET}};
         int_ctrl_reg <= INT_CTRL_RESET;
      end
      else if (wr_ok)
      begin
         case (reg_req.addr)
            IDX_ALARM_SECONDS:     alarm_reg.seconds <= reg_req.wdata;
            IDX_ALARM_MINUTES:     alarm_reg.minutes <= reg_req.wdata;
            IDX_ALARM_HOURS:       alarm_reg.hours   <= reg_req.wdata;
            IDX_ALARM_DATE:        alarm_reg.date    <= reg_req.wdata;
            IDX_ALARM_MONTH:       alarm_reg.month   <= reg_req.wdata;
            IDX_ALARM_WEEKDAY:     alarm_reg.weekday <= reg_req.wdata;
            IDX_INTERRUPT_CONTROL: int_ctrl_reg      <= reg_req.wdata;
            default:               int_ctrl_reg      <= int_ctrl_reg;
         endcase
      end
   end

   // reset value is mode A, the standard switchover
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         backup_ctrl_reg <= BACKUP_CTRL_RESET;
      else if (wr_ok && reg_req.addr == IDX_BACKUP_CONTROL)
         backup_ctrl_reg <= reg_req.wdata[1:0];
   end

   // ----------------------------------------------------------------
   // alarm flag
   // ----------------------------------------------------------------
   // a match in the same cycle as a clear keeps the flag set
   always_comb
   begin
      flag_next = match_evt || (flag_reg && !flag_clear);
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         flag_reg <= 1'b0;
      else
         flag_reg <= flag_next;
   end

   // ----------------------------------------------------------------
   // interrupt pin sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next     = state_reg;
      pulse_cnt_next = pulse_cnt_reg;
      case (state_reg)
         IRQ_IDLE:
         begin
            if (match_evt && repeat_mode)
            begin
               state_next     = IRQ_PULSE;
               pulse_cnt_next = PULSE_LAST;
            end
            else if (match_evt)
               state_next = IRQ_HOLD;
         end
         IRQ_HOLD:
         begin
            // held low until software clears the flag
            if (!flag_next)
               state_next = IRQ_IDLE;
         end
         IRQ_PULSE:
         begin
            // pulse ends on its own; the flag plays no part
            if (pulse_cnt_reg == 8'h00)
               state_next = IRQ_IDLE;
            else
               pulse_cnt_next = pulse_cnt_reg - 8'h01;
         end
         default:
         begin
            state_next     = IRQ_IDLE;
            pulse_cnt_next = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_reg     <= IRQ_IDLE;
         pulse_cnt_reg <= 8'h00;
      end
      else
      begin
         state_reg     <= state_next;
         pulse_cnt_reg <= pulse_cnt_next;
      end
   end

   // pin is never gated by the supply state, so it keeps working on battery
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         irq_oe  <= 1'b0;
         irq_out <= 1'b0;
      end
      else
      begin
         irq_oe  <= (state_next != IRQ_IDLE);
         irq_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read path and status outputs
   // ----------------------------------------------------------------
   // reads return zero while the bus is inhibited, like a dead interface
   always_comb
   begin
      rdata_next = 8'h00;
      if (bus_enable)
      begin
         case (reg_req.addr)
            IDX_ALARM_SECONDS:     rdata_next = alarm_reg.seconds;
            IDX_ALARM_MINUTES:     rdata_next = alarm_reg.minutes;
            IDX_ALARM_HOURS:       rdata_next = alarm_reg.hours;
            IDX_ALARM_DATE:        rdata_next = alarm_reg.date;
            IDX_ALARM_MONTH:       rdata_next = alarm_reg.month;
            IDX_ALARM_WEEKDAY:     rdata_next = alarm_reg.weekday;
            IDX_INTERRUPT_CONTROL: rdata_next = int_ctrl_reg;
            IDX_STATUS:
            begin
               rdata_next[STATUS_ALARM0_BIT] = flag_reg;
               rdata_next[STATUS_BACKUP_BIT] = in_backup;
               rdata_next[STATUS_BUS_BIT]    = bus_enable;
            end
            IDX_BACKUP_CONTROL:    rdata_next = {6'h00, backup_ctrl_reg};
            default:               rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         reg_rdata     <= 8'h00;
         reg_ready     <= 1'b0;
         backup_active <= 1'b0;
         bus_active    <= 1'b1;
      end
      else
      begin
         reg_rdata     <= rdata_next;
         reg_ready     <= bus_enable;
         backup_active <= in_backup;
         bus_active    <= bus_enable;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_flag_on_match: assert property (@(posedge clk_sys) disable iff (srst)
      match_evt |=> (flag_reg && irq_oe && !irq_out))
      else $error("match did not set flag and pull pin low");

   a_enable_gates: assert property (@(posedge clk_sys) disable iff (srst)
      !int_ctrl_reg[ALARM0_ENABLE_BIT] |-> !match_evt)
      else $error("alarm event while alarm disabled");

   a_fields_match: assert property (@(posedge clk_sys) disable iff (srst)
      match_evt |-> ((!alarm_reg.minutes[7] || alarm_reg.minutes[6:0] == cur_time.minutes[6:0])
                  && (!alarm_reg.hours[7] || alarm_reg.hours[6:0] == cur_time.hours[6:0])
                  && (!alarm_reg.date[7] || alarm_reg.date[6:0] == cur_time.date[6:0])))
      else $error("alarm fired with an enabled field unequal");

   a_rollover_eval: assert property (@(posedge clk_sys) disable iff (srst)
      (match_evt && !alarm_reg.seconds[7]) |-> (cur_time.seconds == SECONDS_ROLLOVER))
      else $error("minute-level alarm fired away from rollover");

   a_single_hold: assert property (@(posedge clk_sys) disable iff (srst)
      (state_reg == IRQ_HOLD && flag_reg && !flag_clear) |=> (irq_oe && flag_reg))
      else $error("single alarm output released before flag clear");

   a_pulse_bounded: assert property (@(posedge clk_sys) disable iff (srst)
      (match_evt && repeat_mode && state_reg == IRQ_IDLE)
         |=> irq_oe [*8] ##242 irq_oe ##1 !irq_oe)
      else $error("repeat pulse width wrong");

   a_repeat_no_clear: assert property (@(posedge clk_sys) disable iff (srst)
      (match_evt && repeat_mode && state_reg == IRQ_IDLE && flag_reg) |=> (state_reg == IRQ_PULSE))
      else $error("repeat pulse blocked by uncleared flag");

   a_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
      (match_evt && flag_clear) |=> flag_reg)
      else $error("flag clear beat a simultaneous match");

   a_bus_gated: assert property (@(posedge clk_sys) disable iff (srst)
      (!bus_enable && reg_req.write_en) |=> ($stable(int_ctrl_reg) && $stable(alarm_reg)))
      else $error("register written while bus inhibited");

   a_irq_in_backup: assert property (@(posedge clk_sys) disable iff (srst)
      (in_backup && match_evt && state_reg != IRQ_PULSE) |=> irq_oe)
      else $error("interrupt pin silent during backup");

endmodule

// ==== verif/host_bus_model.sv ====
`timescale 1ns/10ps
module host_bus_model
   import rtc_alarm_pkg::*;
(
   // clock
   input  wire logic       clk_sys,
   // register port of the device
   output reg_req_t        reg_req,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_ready
);
   // an idle data bus shows the inverse of the last byte, never a stale copy
   initial reg_req = '{1'b0, 4'h0, 8'hFF};

   // host and pull-ups sit on the battery rail, so it keeps talking in backup
   task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_req = '{1'b1, a, d};
      @(posedge clk_sys);
      #1;
      reg_req = '{1'b0, a, ~d};
   endtask

   task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_req.addr = a;
      @(posedge clk_sys);
      #1;
      d = reg_rdata;
   endtask
endmodule

// ==== verif/test_rtc_alarm_and_backup_mode.sv ====
`timescale 1ns/10ps
`define CHK(what, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module test_rtc_alarm_and_backup_mode
   import rtc_alarm_pkg::*;
();
   typedef struct packed {logic [47:0] a; logic [7:0] c; time_bcd_t t; logic e;} row_t;

   logic       clk_sys;
   logic       srst;
   reg_req_t   reg_req;
   logic [7:0] reg_rdata;
   logic       reg_ready;
   time_bcd_t  cur_time;
   logic       sec_tick;
   logic       vdd_below_trip;
   logic       vdd_below_bat;
   logic       irq_out;
   logic       irq_oe;
   logic       backup_active;
   logic       bus_active;
   logic [7:0] rd;
   logic [1:0] m;
   int         err_count = 0;
   int         checks = 0;
   int         cycles = 0;
   int         n;
   row_t       rows [7];

   rtc_alarm_and_backup_mode rtc_alarm_and_backup_mode_i (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_ready(reg_ready), .cur_time(cur_time), .sec_tick(sec_tick),
      .vdd_below_trip(vdd_below_trip), .vdd_below_bat(vdd_below_bat), .irq_out(irq_out), .irq_oe(irq_oe),
      .backup_active(backup_active), .bus_active(bus_active));
   host_bus_model host_bus_model_i (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_ready(reg_ready));

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // whole run needs about a thousand cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic load(input row_t r);
      @(posedge clk_sys);
      #1;
      srst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      for (int k = 0; k < 6; k++)
         host_bus_model_i.write_reg(4'(k), r.a[47-8*k -: 8]);
      host_bus_model_i.write_reg(IDX_INTERRUPT_CONTROL, r.c);
   endtask

   task automatic tick(input time_bcd_t t);
      @(posedge clk_sys);
      #1;
      cur_time = t;
      sec_tick = 1'b1;
      @(posedge clk_sys);
      #1;
      sec_tick = 1'b0;
   endtask

   initial
   begin
      srst = 1'b1;
      sec_tick = 1'b0;
      cur_time = 48'h0;
      vdd_below_trip = 1'b0;
      vdd_below_bat = 1'b0;
      rows = '{'{48'h00B091818100, 8'h20, 48'h003011010103, 1'b1},
               '{48'h00B091818100, 8'h20, 48'h003111010103, 1'b0},
               '{48'h00B091818100, 8'h00, 48'h003011010103, 1'b0},
               '{48'h00B091818100, 8'h20, 48'h053011010103, 1'b0},
               '{48'hB00000000000, 8'hA0, 48'h304507090402, 1'b1},
               '{48'hB00000000000, 8'hA0, 48'h314507090402, 1'b0},
               '{48'h00B091818100, 8'h20, 48'h003012010103, 1'b0}};
      repeat (5) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      for (int k = 0; k < 10; k++)
      begin
         host_bus_model_i.read_reg(4'(k), rd);
         `CHK("reset value", (k == 7) ? 8'h04 : 8'h00, rd)
      end
      `CHK("reg_ready", 1'b1, reg_ready)
      for (int i = 0; i < 7; i++)
      begin
         load(rows[i]);
         tick(rows[i].t);
         `CHK("irq_oe", rows[i].e, irq_oe)
         `CHK("irq_out", 1'b0, irq_out)
         host_bus_model_i.read_reg(IDX_STATUS, rd);
         `CHK("alarm0_flag", rows[i].e, rd[STATUS_ALARM0_BIT])
      end
      // single event holds the pin until software clears the flag
      load(rows[0]);
      tick(rows[0].t);
      repeat (300) @(posedge clk_sys);
      #1;
      `CHK("irq held", 1'b1, irq_oe)
      // a clear landing on the same edge as a new match must lose
      fork
         tick(rows[0].t);
         host_bus_model_i.write_reg(IDX_STATUS, 8'h00);
      join
      `CHK("set beats clear", 1'b1, irq_oe)
      host_bus_model_i.read_reg(IDX_STATUS, rd);
      `CHK("flag after race", 1'b1, rd[STATUS_ALARM0_BIT])
      host_bus_model_i.write_reg(IDX_STATUS, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("irq cleared", 1'b0, irq_oe)
      // repeat mode: fixed pulse, and a second pulse with the flag never cleared
      load(rows[4]);
      tick(rows[4].t);
      n = 0;
      while (irq_oe === 1'b1 && n < 400)
      begin
         n++;
         @(posedge clk_sys);
         #1;
      end
      `CHK("pulse width", PULSE_CYCLES, n)
      tick(48'h304607090402);
      `CHK("second pulse", 1'b1, irq_oe)
      host_bus_model_i.read_reg(IDX_STATUS, rd);
      `CHK("flag kept", 1'b1, rd[STATUS_ALARM0_BIT])
      for (int i = 0; i < 4; i++)
      begin
         m = 2'(i);
         load(rows[4]);
         host_bus_model_i.write_reg(IDX_BACKUP_CONTROL, {6'h00, m});
         vdd_below_bat = 1'b1;
         repeat (4) @(posedge clk_sys);
         #1;
         `CHK("legacy switch", m[SWITCHOVER_BIT], backup_active)
         vdd_below_trip = 1'b1;
         repeat (4) @(posedge clk_sys);
         #1;
         `CHK("in backup", 1'b1, backup_active)
         `CHK("bus in backup", ~m[BUS_INHIBIT_BIT], bus_active)
         `CHK("ready in backup", ~m[BUS_INHIBIT_BIT], reg_ready)
         tick(rows[4].t);
         `CHK("irq in backup", 1'b1, irq_oe)
         host_bus_model_i.write_reg(IDX_ALARM_SECONDS, 8'h55);
         vdd_below_bat = 1'b0;
         vdd_below_trip = 1'b0;
         repeat (4) @(posedge clk_sys);
         host_bus_model_i.read_reg(IDX_ALARM_SECONDS, rd);
         `CHK("write in backup", m[1] ? 8'hB0 : 8'h55, rd)
      end
      report_and_stop();
   end
endmodule
